// *** verilog/rup_uart_top.sv ***
// RS485 UART port: host register file, baud generator, transmitter
// with a 16-word holding buffer, receiver and transceiver enable.
// Host strobes are on core_clk_i; serial input and mode pin are not.
`timescale 1ns/100ps

module rup_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic full;
		logic empty;
		logic ready;
	} rup_fifo_st_t;

	rup_fifo_st_t state_reg;
	rup_fifo_st_t state_next;
	logic push;
	logic pop;

	// Pointer and count update; depth must be a power of two
	always_comb begin
		state_next = state_reg;
		push = in_valid_i && !state_reg.full;
		pop = out_ready_i && !state_reg.empty;
		if (push) begin
			state_next.mem[state_reg.wp] = in_data_i;
			state_next.wp = state_reg.wp + 1'b1;
		end
		if (pop) begin
			state_next.rp = state_reg.rp + 1'b1;
		end
		state_next.cnt = state_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
		state_next.full = state_next.cnt == (AW+1)'(DEPTH);
		state_next.empty = state_next.cnt == '0;
		state_next.ready = !state_next.full;
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state_reg <= '0;
			state_reg.empty <= 1'b1;
			state_reg.ready <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// Flags come from flops, so ready is glitch free
	assign in_ready_o = state_reg.ready;
	assign out_valid_o = !state_reg.empty;
	assign out_data_o = state_reg.mem[state_reg.rp];
endmodule

// Function
// - Frame format bit 7 maps offsets 0 and 1 onto the baud divisor.
// - With divisor selected, offset 0 takes low byte, offset 1 high.
// - Baud is 1.843 MHz over 16 times divisor: 1 gives 115200.
// - Format bits 1:0 give character length minus five.
// - Format bit 2 picks one or two stop bits.
// - Format bits 3..6 set parity and break; software writes zero normally.
// - Line output bit 1 drives the transceiver enable in manual mode.
// - Automatic mode enables the driver while data is pending.
// - Line output bit 3 gates the interrupt; bit 2 does nothing.
// - Line state bit 0 is set while a received byte waits.
// - Offset 2 reports the pending source or that none is pending.
// - Line state bit 5 is set when the holding register is empty.
// - RTS only enables the local driver; never sent nor handshake.
// - Either RTS control or automatic enable runs RS485 traffic.
// - Address lines A2..A0 select one of eight registers.
module rup_uart_top
	import rup_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// Host register port
	input wire logic [2:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic tx_ready_o,
	output logic irq_o,
	// Line side
	input wire logic rx_i,
	input wire logic auto_mode_i,
	output logic tx_o,
	output logic drv_en_o
);
	rup_top_t state_reg;
	rup_top_t state_next;
	logic f_valid;
	logic [7:0] f_data;
	logic f_pop;
	logic push;
	logic div_sel;
	logic uclk_en;
	logic rxd;
	logic [15:0] divisor;
	logic [2:0] last_bit;
	logic [7:0] int_src;
	logic [7:0] line_state;

	// Holding buffer; a full buffer pulls tx_ready_o low
	rup_fifo #(.WIDTH(DATA_W), .DEPTH(TX_DEPTH)) u_hold (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.in_valid_i(push),
		.in_ready_o(tx_ready_o),
		.in_data_i(wdata_i),
		.out_valid_o(f_valid),
		.out_ready_i(f_pop),
		.out_data_o(f_data)
	);

	// Decoded views of current state
	always_comb begin
		div_sel = state_reg.fmt[FMT_DIV_SEL];
		push = wr_i && addr_i == OFS_RX_TX && !div_sel;
		divisor = {state_reg.div_hi, state_reg.div_lo};
		rxd = state_reg.rx_s[1];
		last_bit = 3'(state_reg.fmt[1:0]) + LEN_MIN_M1;
		uclk_en = state_reg.phase >= PHASE_MOD - PHASE_STEP;
		line_state = {1'b0, !f_valid && state_reg.tx_st == TX_IDLE,
			!f_valid, state_reg.bi, state_reg.fe, state_reg.pe,
			state_reg.oe, state_reg.dr};
		// Priority: line errors, then data, then holding empty
		if (state_reg.ien[IEN_LS] && (state_reg.oe || state_reg.pe ||
			state_reg.fe || state_reg.bi)) begin
			int_src = INT_LS;
		end else if (state_reg.ien[IEN_RX] && state_reg.dr) begin
			int_src = INT_RX;
		end else if (state_reg.ien[IEN_THRE] && state_reg.thre_ip) begin
			int_src = INT_THRE;
		end else begin
			int_src = INT_NONE;
		end
	end

	// Next state of the whole port
	always_comb begin
		state_next = state_reg;
		f_pop = 1'b0;
		state_next.tick = 1'b0;
		state_next.rx_s = {state_reg.rx_s[0], rx_i};
		state_next.auto_s = {state_reg.auto_s[0], auto_mode_i};
		state_next.hv_d = f_valid;

		// UART reference at 1.843 MHz, then divide by the divisor
		if (uclk_en) begin
			state_next.phase = state_reg.phase - (PHASE_MOD - PHASE_STEP);
			// Divisor zero stops the generator rather than wrapping
			if (divisor != 16'h0000) begin
				if (state_reg.dcnt >= divisor - 16'h0001) begin
					state_next.dcnt = 16'h0000;
					state_next.tick = 1'b1;
				end else begin
					state_next.dcnt = state_reg.dcnt + 16'h0001;
				end
			end
		end else begin
			state_next.phase = state_reg.phase + PHASE_STEP;
		end

		// Register writes
		if (wr_i) begin
			case (addr_i)
				OFS_RX_TX: begin
					if (div_sel) begin
						state_next.div_lo = wdata_i;
					end else begin
						state_next.thre_ip = 1'b0;
					end
				end
				OFS_DIV_HI: begin
					if (div_sel) begin
						state_next.div_hi = wdata_i;
					end else begin
						state_next.ien = wdata_i;
					end
				end
				OFS_FRAME_FMT: state_next.fmt = wdata_i;
				OFS_LINE_OUT: state_next.lout = wdata_i;
				OFS_SCRATCH: state_next.scratch = wdata_i;
				default: ;
			endcase
		end

		// Register reads; clears come before sets below
		if (rd_i) begin
			case (addr_i)
				OFS_RX_TX: begin
					if (div_sel) begin
						state_next.rd_data = state_reg.div_lo;
					end else begin
						state_next.rd_data = state_reg.rxbuf;
						state_next.dr = 1'b0;
					end
				end
				OFS_DIV_HI: state_next.rd_data = div_sel ?
					state_reg.div_hi : state_reg.ien;
				OFS_INT_SRC: begin
					state_next.rd_data = int_src;
					if (int_src == INT_THRE) begin
						state_next.thre_ip = 1'b0;
					end
				end
				OFS_FRAME_FMT: state_next.rd_data = state_reg.fmt;
				OFS_LINE_OUT: state_next.rd_data = state_reg.lout;
				OFS_LINE_STATE: begin
					state_next.rd_data = line_state;
					state_next.oe = 1'b0;
					state_next.pe = 1'b0;
					state_next.fe = 1'b0;
					state_next.bi = 1'b0;
				end
				OFS_SCRATCH: state_next.rd_data = state_reg.scratch;
				default: state_next.rd_data = 8'h00;
			endcase
		end

		// Holding empty event; wins over a clear in the same cycle
		if (state_reg.hv_d && !f_valid) begin
			state_next.thre_ip = 1'b1;
		end

		// Transmitter: 16 ticks per bit
		if (state_reg.tx_st == TX_IDLE) begin
			if (f_valid) begin
				f_pop = 1'b1;
				state_next.tx_sh = f_data;
				state_next.tx_st = TX_START;
				state_next.tx_ph = 4'h0;
				state_next.tx_bit = 3'h0;
				state_next.tx_stop = 1'b0;
				state_next.tx_par = !state_reg.fmt[FMT_PAR_EVEN];
			end
		end else if (state_reg.tick) begin
			state_next.tx_ph = state_reg.tx_ph + 4'h1;
			if (state_reg.tx_ph == PH_LAST) begin
				case (state_reg.tx_st)
					TX_START: state_next.tx_st = TX_DATA;
					TX_DATA: begin
						state_next.tx_sh = {1'b0, state_reg.tx_sh[7:1]};
						state_next.tx_par = state_reg.tx_par ^
							state_reg.tx_sh[0];
						state_next.tx_bit = state_reg.tx_bit + 3'h1;
						if (state_reg.tx_bit == last_bit) begin
							state_next.tx_st =
								state_reg.fmt[FMT_PAR_EN] ? TX_PAR : TX_STOP;
						end
					end
					TX_PAR: state_next.tx_st = TX_STOP;
					TX_STOP: begin
						state_next.tx_stop = 1'b1;
						// Second stop bit only when selected
						if (state_reg.tx_stop || !state_reg.fmt[FMT_STOP2]) begin
							state_next.tx_st = TX_IDLE;
						end
					end
					default: state_next.tx_st = TX_IDLE;
				endcase
			end
		end

		// Line level per bit; break holds the line low
		case (state_reg.tx_st)
			TX_START: state_next.tx_line = 1'b0;
			TX_DATA: state_next.tx_line = state_reg.tx_sh[0];
			TX_PAR: state_next.tx_line = state_reg.fmt[FMT_PAR_STICK] ?
				!state_reg.fmt[FMT_PAR_EVEN] : state_reg.tx_par;
			default: state_next.tx_line = 1'b1;
		endcase
		if (state_reg.fmt[FMT_BREAK]) begin
			state_next.tx_line = 1'b0;
		end

		// Receiver: start checked at mid bit, data sampled each 16 ticks
		if (state_reg.rx_st == RX_IDLE) begin
			if (!rxd) begin
				state_next.rx_st = RX_START;
				state_next.rx_ph = 4'h0;
				state_next.rx_bit = 3'h0;
				state_next.rx_sh = 8'h00;
				state_next.rx_par = !state_reg.fmt[FMT_PAR_EVEN];
			end
		end else if (state_reg.tick) begin
			state_next.rx_ph = state_reg.rx_ph + 4'h1;
			case (state_reg.rx_st)
				RX_START: begin
					if (state_reg.rx_ph == PH_MID) begin
						state_next.rx_ph = 4'h0;
						// A short glitch returns to idle
						state_next.rx_st = rxd ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (state_reg.rx_ph == PH_LAST) begin
						state_next.rx_sh[state_reg.rx_bit] = rxd;
						state_next.rx_par = state_reg.rx_par ^ rxd;
						state_next.rx_bit = state_reg.rx_bit + 3'h1;
						if (state_reg.rx_bit == last_bit) begin
							state_next.rx_st =
								state_reg.fmt[FMT_PAR_EN] ? RX_PAR : RX_STOP;
						end
					end
				end
				RX_PAR: begin
					if (state_reg.rx_ph == PH_LAST) begin
						state_next.rx_par = state_reg.fmt[FMT_PAR_STICK] ?
							rxd == state_reg.fmt[FMT_PAR_EVEN] :
							state_reg.rx_par ^ rxd;
						state_next.rx_st = RX_STOP;
					end
				end
				RX_STOP: begin
					// Only the first stop bit is checked
					if (state_reg.rx_ph == PH_LAST) begin
						state_next.rxbuf = state_reg.rx_sh;
						state_next.dr = 1'b1;
						if (state_reg.dr) begin
							state_next.oe = 1'b1;
						end
						if (state_reg.fmt[FMT_PAR_EN] && state_reg.rx_par) begin
							state_next.pe = 1'b1;
						end
						if (!rxd) begin
							state_next.fe = 1'b1;
							state_next.bi = state_reg.rx_sh == 8'h00;
						end
						state_next.rx_st = RX_IDLE;
					end
				end
				default: state_next.rx_st = RX_IDLE;
			endcase
		end

		// Driver enable: RTS is local only, never on the line
		if (state_reg.auto_s[1]) begin
			state_next.drv_en = f_valid || state_reg.tx_st != TX_IDLE;
		end else begin
			state_next.drv_en = state_reg.lout[OUT_RTS];
		end

		// Interrupt leaves only through the gate bit
		state_next.irq = state_reg.lout[OUT_IRQ_GATE] &&
			int_src != INT_NONE;
	end

	// Single register stage for all state
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state_reg <= '0;
			state_reg.div_lo <= DIV_LO_RST;
			state_reg.div_hi <= DIV_HI_RST;
			state_reg.rx_s <= 2'h3;
			state_reg.tx_line <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rdata_o = state_reg.rd_data;
	assign irq_o = state_reg.irq;
	assign tx_o = state_reg.tx_line;
	assign drv_en_o = state_reg.drv_en;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (srst_i);

	// Checks
	a_div_low_load: assert property (
		wr_i && addr_i == OFS_RX_TX && div_sel
		|=> state_reg.div_lo == $past(wdata_i) && !$past(push))
		else $error("divisor low byte not loaded");
	a_div_high_load: assert property (
		wr_i && addr_i == OFS_DIV_HI && div_sel
		|=> state_reg.div_hi == $past(wdata_i))
		else $error("divisor high byte not loaded");
	a_rx_read_clear: assert property (
		rd_i && addr_i == OFS_RX_TX && !div_sel &&
		state_reg.rx_st != RX_STOP |=> !state_reg.dr)
		else $error("data ready survived a buffer read");
	a_status_ready: assert property (
		rd_i && addr_i == OFS_LINE_STATE
		|=> rdata_o[0] == $past(state_reg.dr))
		else $error("line state bit 0 wrong");
	// Idle shifter takes the character a cycle later, so only one cycle
	a_hold_empty: assert property (push |=> !line_state[5])
		else $error("holding empty flag not cleared");
	a_src_none: assert property (
		rd_i && addr_i == OFS_INT_SRC && int_src == INT_NONE
		|=> rdata_o == INT_NONE)
		else $error("source register misreports idle");
	a_rts_manual: assert property (
		!state_reg.auto_s[1] ##1 !state_reg.auto_s[1]
		|-> drv_en_o == $past(state_reg.lout[OUT_RTS]))
		else $error("driver enable not following RTS");
	a_auto_drive: assert property (
		state_reg.auto_s[1] && state_reg.tx_st != TX_IDLE
		|=> drv_en_o)
		else $error("automatic mode left driver off");
	a_irq_gate: assert property (
		!state_reg.lout[OUT_IRQ_GATE] |=> !irq_o)
		else $error("interrupt passed a closed gate");
	a_start_bit: assert property (
		state_reg.tx_st == TX_START && !state_reg.fmt[FMT_BREAK]
		|=> !tx_o)
		else $error("start bit not low");

	c_tx_frame: cover property (state_reg.tx_st == TX_STOP ##1
		state_reg.tx_st == TX_IDLE);
	c_rx_byte: cover property (!state_reg.dr ##1 state_reg.dr);
	c_buf_full: cover property (!tx_ready_o);
	c_irq_out: cover property (irq_o);
endmodule

// *** verilog/rup_pkg.sv ***
// Package for the RS485 UART port: register map, field positions,
// reset values, timing constants and state types.
// Assumes a single 100 MHz core clock shared by every user.
package rup_pkg;

	// Register offsets on host address lines A2..A0
	localparam logic [2:0] OFS_RX_TX = 3'h0;
	localparam logic [2:0] OFS_DIV_HI = 3'h1;
	localparam logic [2:0] OFS_INT_SRC = 3'h2;
	localparam logic [2:0] OFS_FRAME_FMT = 3'h3;
	localparam logic [2:0] OFS_LINE_OUT = 3'h4;
	localparam logic [2:0] OFS_LINE_STATE = 3'h5;
	localparam logic [2:0] OFS_SPARE = 3'h6;
	localparam logic [2:0] OFS_SCRATCH = 3'h7;

	// Frame format fields
	localparam int FMT_STOP2 = 2;
	localparam int FMT_PAR_EN = 3;
	localparam int FMT_PAR_EVEN = 4;
	localparam int FMT_PAR_STICK = 5;
	localparam int FMT_BREAK = 6;
	localparam int FMT_DIV_SEL = 7;
	localparam logic [2:0] LEN_MIN_M1 = 3'h4;

	// Line output control fields
	localparam int OUT_RTS = 1;
	localparam int OUT_IRQ_GATE = 3;

	// Interrupt enable fields (offset 1 with the latch deselected)
	localparam int IEN_RX = 0;
	localparam int IEN_THRE = 1;
	localparam int IEN_LS = 2;

	// Interrupt source codes
	localparam logic [7:0] INT_NONE = 8'h01;
	localparam logic [7:0] INT_LS = 8'h06;
	localparam logic [7:0] INT_RX = 8'h04;
	localparam logic [7:0] INT_THRE = 8'h02;

	// Reset values
	localparam logic [7:0] DIV_LO_RST = 8'h0c;
	localparam logic [7:0] DIV_HI_RST = 8'h00;

	// Timing: UART reference derived from the core clock by a phase step
	localparam int CORE_CLK_HZ = 100000000;
	localparam int UART_CLK_HZ = 1843000;
	localparam logic [19:0] PHASE_MOD = 20'(CORE_CLK_HZ / 100);
	localparam logic [19:0] PHASE_STEP = 20'(UART_CLK_HZ / 100);
	localparam logic [3:0] PH_MID = 4'h7;
	localparam logic [3:0] PH_LAST = 4'hf;

	// Transmit buffer
	localparam int DATA_W = 8;
	localparam int TX_DEPTH = 16;

	typedef enum logic [2:0] {
		TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
	} rup_tx_st_t;

	typedef enum logic [2:0] {
		RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
	} rup_rx_st_t;

	typedef struct packed {
		logic [19:0] phase;
		logic [15:0] dcnt;
		logic tick;
		logic [7:0] div_lo;
		logic [7:0] div_hi;
		logic [7:0] ien;
		logic [7:0] fmt;
		logic [7:0] lout;
		logic [7:0] scratch;
		logic [7:0] rxbuf;
		logic dr;
		logic oe;
		logic pe;
		logic fe;
		logic bi;
		logic thre_ip;
		logic hv_d;
		logic [1:0] rx_s;
		logic [1:0] auto_s;
		rup_tx_st_t tx_st;
		logic [7:0] tx_sh;
		logic [2:0] tx_bit;
		logic tx_stop;
		logic tx_par;
		logic [3:0] tx_ph;
		rup_rx_st_t rx_st;
		logic [7:0] rx_sh;
		logic [2:0] rx_bit;
		logic rx_par;
		logic [3:0] rx_ph;
		logic [7:0] rd_data;
		logic irq;
		logic tx_line;
		logic drv_en;
	} rup_top_t;

endpackage

// *** tb/rup_line_peer.sv ***
// Remote node on the RS485 pair: decodes the serial output and sends
// frames into the serial input. Assumes the divisor is loaded as 1.
`timescale 1ns/100ps

module rup_line_peer #(
	parameter real BIT_NS = 8681.5
) (
	// Line side
	input wire logic tx_line_i,
	input wire logic drv_en_i,
	output logic rx_line_o
);
	// Biased pair idles high when nobody drives
	initial rx_line_o = 1'b1;

	// Decode one frame at bit centres; drift is well under a bit
	task automatic recv(input int len, input int stops,
		output logic [7:0] data, output realtime t0, output int bad);
		bad = 0;
		data = 8'h00;
		@(negedge tx_line_i);
		t0 = $realtime;
		#(BIT_NS / 2);
		if (tx_line_i !== 1'b0) bad++;
		for (int i = 0; i < len + stops; i++) begin
			#(BIT_NS);
			if (i < len) data[i] = tx_line_i; // LSB first
			else if (tx_line_i !== 1'b1) bad++; // Stop bits
			if (drv_en_i !== 1'b1) bad++; // Driver held on
		end
	endtask

	// Send one 8-bit frame with one stop bit
	task automatic send(input logic [7:0] b);
		rx_line_o = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < 8; i++) begin
			rx_line_o = b[i];
			#(BIT_NS);
		end
		rx_line_o = 1'b1;
		#(BIT_NS);
	endtask
endmodule

// *** tb/rup_uart_top_tb.sv ***
// Self-checking bench for the RS485 UART port and its holding buffer.
// Assumes a 100 MHz clock and divisor 1 for all serial traffic.
`timescale 1ns/100ps

module rup_uart_top_tb;
	localparam real BIT = 8681.5;
	logic clk, srst, wr, rd, rx, auto_m, tx, drv_en, tx_rdy, irq;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, v, d1, d2, mask;
	logic [7:0] e1, e2;
	logic [7:0] fmts [3] = '{8'h07, 8'h00, 8'h18};
	realtime t1, t2;
	int b1, b2, len, stops, pb, n;
	int n_mismatch = 0;
	int n_checks = 0;

	// Clock
	always #5 clk = ~clk;

	rup_uart_top DUT (.core_clk_i(clk), .srst_i(srst), .addr_i(addr),
		.wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata),
		.tx_ready_o(tx_rdy), .irq_o(irq), .rx_i(rx),
		.auto_mode_i(auto_m), .tx_o(tx), .drv_en_o(drv_en));
	rup_line_peer #(.BIT_NS(BIT)) peer (.tx_line_i(tx),
		.drv_en_i(drv_en), .rx_line_o(rx));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Host strobes are one-cycle pulses launched at the falling edge
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask

	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		@(negedge clk);
		d = rdata;
	endtask

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
		logic [7:0] r;
		rd_reg(a, r);
		chk(r, e);
	endtask

	// Bounded poll of one line state bit
	task automatic wait_st(input int b, input logic val);
		logic [7:0] r;
		int k;
		k = 0;
		do begin
			rd_reg(3'h5, r);
			k++;
		end while (r[b] !== val && k < 6000);
		chk(8'(r[b]), 8'(val));
	endtask

	// Wait for holding empty, then write one character
	task automatic put(input logic [7:0] b);
		wait_st(5, 1'b1);
		wr_reg(3'h0, b);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// Watchdog: about ninety bit times of traffic, near 800 us in all
	initial begin
		#950000;
		n_mismatch++;
		finish_test();
	end

	initial begin
		clk = 1'b0;
		srst = 1'b1;
		{wr, rd, auto_m} = 3'h0;
		addr = 3'h0;
		wdata = 8'h00;
		repeat (6) @(negedge clk);
		srst = 1'b0;
		// Reset state and register map
		chk(8'(tx), 8'h01);
		chk(8'(drv_en), 8'h00);
		rd_chk(3'h2, 8'h01);
		rd_chk(3'h3, 8'h00);
		rd_chk(3'h4, 8'h00);
		rd_chk(3'h5, 8'h60);
		rd_chk(3'h6, 8'h00);
		wr_reg(3'h3, 8'h80);
		rd_chk(3'h0, 8'h0c);
		rd_chk(3'h1, 8'h00);
		wr_reg(3'h0, 8'h01);
		wr_reg(3'h1, 8'h00);
		rd_chk(3'h0, 8'h01);
		rd_chk(3'h1, 8'h00);
		wr_reg(3'h3, 8'h03);
		rd_chk(3'h1, 8'h00);
		rd_chk(3'h3, 8'h03);
		rd_reg(3'h0, v);
		rd_reg(3'h0, v);
		$display("test regs done");
		// Manual driver enable, three frame formats, back-to-back pairs
		rd_reg(3'h4, v);
		wr_reg(3'h4, v | 8'h02);
		@(negedge clk);
		chk(8'(drv_en), 8'h01);
		for (int f = 0; f < 3; f++) begin
			len = int'(fmts[f][1:0]) + 5;
			stops = int'(fmts[f][2]) + 1;
			pb = int'(fmts[f][3]);
			mask = 8'hff >> (8 - len);
			e1 = 8'ha5 & mask;
			e2 = 8'h3c & mask;
			// Even parity bit lands just above the data bits
			if (pb == 1) begin
				e1 = e1 | (8'(^e1) << len);
				e2 = e2 | (8'(^e2) << len);
			end
			wr_reg(3'h3, fmts[f]);
			fork
				begin
					peer.recv(len + pb, stops, d1, t1, b1);
					peer.recv(len + pb, stops, d2, t2, b2);
				end
				begin
					put(8'ha5);
					put(8'h3c);
					rd_reg(3'h5, v);
					chk(8'(v[5]), 8'h00);
				end
			join
			chk(d1, e1);
			chk(d2, e2);
			chk(8'(b1 + b2), 8'h00);
			n = int'((t2 - t1) / BIT);
			chk(8'(n), 8'(1 + len + pb + stops));
		end
		// Break holds the line low; RTS drops only once all is sent
		wait_st(6, 1'b1);
		wr_reg(3'h3, 8'h43);
		@(negedge clk);
		chk(8'(tx), 8'h00);
		wr_reg(3'h3, 8'h03);
		@(negedge clk);
		chk(8'(tx), 8'h01);
		rd_reg(3'h4, v);
		wr_reg(3'h4, v & 8'hfd);
		@(negedge clk);
		chk(8'(drv_en), 8'h00);
		$display("test manual done");
		// Automatic mode ignores the RTS bit
		auto_m = 1'b1;
		wr_reg(3'h4, 8'h02);
		repeat (4) @(negedge clk);
		chk(8'(drv_en), 8'h00);
		wr_reg(3'h3, 8'h03);
		fork
			peer.recv(8, 1, d1, t1, b1);
			put(8'h96);
		join
		chk(d1, 8'h96);
		chk(8'(b1), 8'h00);
		wait_st(6, 1'b1);
		repeat (3) @(negedge clk);
		chk(8'(drv_en), 8'h00);
		$display("test auto done");
		// Receive with interrupt gating
		auto_m = 1'b0;
		wr_reg(3'h4, 8'h00);
		wr_reg(3'h1, 8'h01);
		peer.send(8'h3c);
		wait_st(0, 1'b1);
		rd_chk(3'h2, 8'h04);
		chk(8'(irq), 8'h00);
		wr_reg(3'h4, 8'h08);
		@(negedge clk);
		chk(8'(irq), 8'h01);
		rd_chk(3'h0, 8'h3c);
		rd_reg(3'h5, v);
		chk(8'(v[0]), 8'h00);
		chk(8'(irq), 8'h00);
		rd_chk(3'h2, 8'h01);
		$display("test receive done");
		// Overfill behind a busy shifter; the first two drain in order
		wr_reg(3'h4, 8'h0a);
		wr_reg(3'h3, 8'h00);
		n = 0;
		fork
			begin
				peer.recv(5, 1, d1, t1, b1);
				peer.recv(5, 1, d2, t2, b2);
			end
			begin
				for (int k = 0; k < 20; k++) begin
					if (tx_rdy === 1'b1) n++;
					wr_reg(3'h0, 8'(k));
				end
				chk(8'(tx_rdy), 8'h00);
				rd_reg(3'h5, v);
				chk(8'(v[5]), 8'h00);
			end
		join
		// Sixteen buffered plus one already in the shifter
		chk(8'(n), 8'h11);
		chk(d1, 8'h00);
		chk(d2, 8'h01);
		chk(8'(b1 + b2), 8'h00);
		$display("test overfill done");
		// Abort the queued characters by a reset in mid run
		@(negedge clk);
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		chk(8'(tx_rdy), 8'h01);
		chk(8'(tx), 8'h01);
		chk(8'(drv_en), 8'h00);
		rd_chk(3'h3, 8'h00);
		rd_chk(3'h5, 8'h60);
		$display("test reset done");
		finish_test();
	end
endmodule
